// file: src/priority_crossbar_port_mux.sv
`timescale 1ns/1ps
`default_nettype none
`include "xbar_map.svh"
module priority_crossbar_port_mux
(
	// clock and reset
	input  wire logic              core_clk_i,
	input  wire logic              rst_i,
	// configuration
	input  wire logic [7:0]        pin_skip_reg_i,
	input  wire logic [7:0]        periph_route_reg_a_i,
	input  wire logic [7:0]        periph_route_reg_b_i,
	input  wire logic [7:0]        port_input_mode_i,
	input  wire logic [7:0]        port_output_mode_i,
	input  wire logic [7:0]        port_latch_i,
	// peripheral outputs toward pins
	input  wire logic              serial_transmit_out_i,
	input  wire logic              bus_data_out_i,
	input  wire logic              bus_clock_out_i,
	input  wire logic              comparator_out_i,
	input  wire logic              comparator_async_out_i,
	input  wire logic              sysclk_out_i,
	input  wire logic [2:0]        capture_out_i,
	// peripheral inputs from pins
	output logic                   serial_receive_in_o,
	output logic                   bus_data_in_o,
	output logic                   bus_clock_in_o,
	output logic [2:0]             capture_in_o,
	output logic                   counter_external_input_o,
	output logic                   timer_zero_input_o,
	output logic                   timer_one_input_o,
	// pads
	input  wire logic [7:0]        pad_i,
	output logic [7:0]             pad_o,
	output logic [7:0]             pad_oe_o,
	output logic [7:0]             pullup_en_o,
	output logic [7:0]             port_read_o,
	output logic [7:0]             pin_routed_o
);
	// registered configuration and routing
	xbar_pkg::sig_idx_t pin_sig [`XB_PINS];
	xbar_pkg::sig_idx_t next_pin_sig [`XB_PINS];
	xbar_pkg::pin_vec_t sync1, sync2, sync3, pad_sync, next_pad_sync;
	logic [`XB_SIGS-1:0] sig_en;
	logic                xbar_on;
	logic                weak_pullup_disable;
	logic [7:0]          dig_mode;

	// enable vector in priority order (lower index wins)
	always_comb
	begin
		sig_en = '0;
		sig_en[`XB_S_TX]     = periph_route_reg_a_i[0];
		sig_en[`XB_S_RX]     = periph_route_reg_a_i[1];
		sig_en[`XB_S_SDA]    = periph_route_reg_a_i[2]; // see [RULE_07]
		sig_en[`XB_S_SCL]    = periph_route_reg_a_i[2]; // see [RULE_07]
		sig_en[`XB_S_SYSCLK] = periph_route_reg_a_i[3];
		sig_en[`XB_S_CMP]    = periph_route_reg_a_i[4];
		sig_en[`XB_S_CMPA]   = periph_route_reg_a_i[5];
		// capture count 0..3 in order, see [RULE_22]
		sig_en[`XB_S_CAP0]   = |periph_route_reg_a_i[7:6];
		sig_en[`XB_S_CAP1]   = periph_route_reg_a_i[7];
		sig_en[`XB_S_CAP2]   = &periph_route_reg_a_i[7:6];
		sig_en[`XB_S_ECI]    = periph_route_reg_b_i[0];
		sig_en[`XB_S_T0]     = periph_route_reg_b_i[1];
		sig_en[`XB_S_T1]     = periph_route_reg_b_i[2];
	end

	// priority walk; pin 7 skip bit masked off
	always_comb
	begin
		logic [7:0] taken;
		logic       placed;
		taken = pin_skip_reg_i & `XB_SKIP_MASK; // see [RULE_05] [RULE_06]
		placed = 1'b0;
		for (int p = 0; p < `XB_PINS; p++)
			next_pin_sig[p] = `XB_NONE;
		// serial pair is fixed, see [RULE_03]
		if (sig_en[`XB_S_TX])
		begin
			next_pin_sig[`XB_TX_PIN] = xbar_pkg::sig_idx_t'(`XB_S_TX);
			taken[`XB_TX_PIN] = 1'b1;
		end
		if (sig_en[`XB_S_RX])
		begin
			next_pin_sig[`XB_RX_PIN] = xbar_pkg::sig_idx_t'(`XB_S_RX);
			taken[`XB_RX_PIN] = 1'b1;
		end
		// lowest free pin per signal, see [RULE_01] [RULE_02] [RULE_04]
		for (int s = `XB_S_SDA; s < `XB_SIGS; s++)
		begin
			placed = 1'b0;
			for (int p = 0; p < `XB_PINS; p++)
			begin
				if (sig_en[s] && !placed && !taken[p])
				begin
					next_pin_sig[p] = xbar_pkg::sig_idx_t'(s);
					taken[p] = 1'b1;
					placed = 1'b1;
				end
			end
			// unplaced signals dropped, see [RULE_23]
		end
	end

	// registers; routing follows config one edge later, see [RULE_24]
	always_ff @(posedge core_clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			for (int p = 0; p < `XB_PINS; p++)
				pin_sig[p] <= `XB_NONE;
			xbar_on             <= 1'b0;
			weak_pullup_disable <= 1'b0;
			dig_mode            <= 8'hFF; // see [RULE_11]
			sync1               <= 8'h00;
			sync2               <= 8'h00;
			sync3               <= 8'h00;
			pad_sync            <= 8'h00;
		end
		else
		begin
			pin_sig             <= next_pin_sig;
			xbar_on             <= periph_route_reg_b_i[6]; // see [RULE_19]
			weak_pullup_disable <= periph_route_reg_b_i[7];
			dig_mode            <= port_input_mode_i; // see [RULE_11]
			sync1               <= pad_i;
			sync2               <= sync1;
			sync3               <= sync2;
			pad_sync            <= next_pad_sync;
		end
	end

	// pad level accepted when stages two and three agree
	always_comb
	begin
		for (int p = 0; p < `XB_PINS; p++)
			next_pad_sync[p] = (sync2[p] == sync3[p]) ? sync3[p] : pad_sync[p];
	end

	// per-pin output driver, enable and pullup
	always_comb
	begin
		logic val;
		logic od;
		logic in_only;
		val = 1'b1;
		od  = 1'b0;
		in_only = 1'b0;
		pin_routed_o = '0;
		for (int p = 0; p < `XB_PINS; p++)
		begin
			// leftover pins are gpio, see [RULE_08]
			val = port_latch_i[p];
			od  = !port_output_mode_i[p]; // see [RULE_13]
			in_only = 1'b0;
			if (pin_sig[p] != `XB_NONE && xbar_on)
				pin_routed_o[p] = 1'b1;
			case (pin_sig[p])
				xbar_pkg::sig_idx_t'(`XB_S_TX):     val = serial_transmit_out_i;
				xbar_pkg::sig_idx_t'(`XB_S_SDA):    val = bus_data_out_i;
				xbar_pkg::sig_idx_t'(`XB_S_SCL):    val = bus_clock_out_i;
				xbar_pkg::sig_idx_t'(`XB_S_CMP):    val = comparator_out_i;
				xbar_pkg::sig_idx_t'(`XB_S_CMPA):   val = comparator_async_out_i;
				xbar_pkg::sig_idx_t'(`XB_S_SYSCLK): val = sysclk_out_i;
				xbar_pkg::sig_idx_t'(`XB_S_CAP0):   val = capture_out_i[0];
				xbar_pkg::sig_idx_t'(`XB_S_CAP1):   val = capture_out_i[1];
				xbar_pkg::sig_idx_t'(`XB_S_CAP2):   val = capture_out_i[2];
				// inputs leave the pin released
				xbar_pkg::sig_idx_t'(`XB_S_RX),
				xbar_pkg::sig_idx_t'(`XB_S_ECI),
				xbar_pkg::sig_idx_t'(`XB_S_T0),
				xbar_pkg::sig_idx_t'(`XB_S_T1):     val = 1'b1;
				default:                            val = port_latch_i[p];
			endcase
			// input-only pins must never drive, even push-pull
			if (pin_sig[p] == xbar_pkg::sig_idx_t'(`XB_S_RX) ||
				pin_sig[p] == xbar_pkg::sig_idx_t'(`XB_S_ECI) ||
				pin_sig[p] == xbar_pkg::sig_idx_t'(`XB_S_T0) ||
				pin_sig[p] == xbar_pkg::sig_idx_t'(`XB_S_T1))
				in_only = 1'b1;
			if (pin_sig[p] == xbar_pkg::sig_idx_t'(`XB_S_SDA) ||
				pin_sig[p] == xbar_pkg::sig_idx_t'(`XB_S_SCL))
				od = 1'b1; // see [RULE_14]
			// disabled crossbar or analog pin: no drive, see [RULE_17]
			pad_o[p] = 1'b0;
			pad_oe_o[p] = 1'b0;
			if (xbar_on && dig_mode[p]) // see [RULE_18] [RULE_12]
			begin
				pad_o[p]    = od ? 1'b0 : val;
				pad_oe_o[p] = in_only ? 1'b0 : (od ? !val : 1'b1);
			end
			// pullup: open-drain or crossbar disabled, not driving low
			pullup_en_o[p] = dig_mode[p] && !weak_pullup_disable
				&& (!xbar_on || od) && !(pad_oe_o[p] && !pad_o[p]); // see [RULE_15] [RULE_16]
		end
	end

	// input side; analog reads zero
	always_comb
	begin
		logic [7:0] rd;
		rd = pad_sync & dig_mode; // see [RULE_21] [RULE_12]
		port_read_o = rd;
		serial_receive_in_o      = 1'b1;
		bus_data_in_o            = 1'b1;
		bus_clock_in_o           = 1'b1;
		capture_in_o             = 3'h0;
		counter_external_input_o = 1'b0;
		timer_zero_input_o       = 1'b0;
		timer_one_input_o        = 1'b0;
		if (xbar_on)
			for (int p = 0; p < `XB_PINS; p++)
				case (pin_sig[p])
					xbar_pkg::sig_idx_t'(`XB_S_RX):   serial_receive_in_o = rd[p];
					xbar_pkg::sig_idx_t'(`XB_S_SDA):  bus_data_in_o = rd[p];
					xbar_pkg::sig_idx_t'(`XB_S_SCL):  bus_clock_in_o = rd[p];
					xbar_pkg::sig_idx_t'(`XB_S_CAP0): capture_in_o[0] = rd[p];
					xbar_pkg::sig_idx_t'(`XB_S_CAP1): capture_in_o[1] = rd[p];
					xbar_pkg::sig_idx_t'(`XB_S_CAP2): capture_in_o[2] = rd[p];
					xbar_pkg::sig_idx_t'(`XB_S_ECI):  counter_external_input_o = rd[p];
					xbar_pkg::sig_idx_t'(`XB_S_T0):   timer_zero_input_o = rd[p];
					xbar_pkg::sig_idx_t'(`XB_S_T1):   timer_one_input_o = rd[p];
					default:                          ;
				endcase
	end

	// checks
	chk_tx_fixed_pin: assert property (@(posedge core_clk_i) disable iff (rst_i)
		periph_route_reg_a_i[0] |=> pin_sig[4] == 4'h0) // see [RULE_03]
		else $error("tx not on pin 4");
	chk_rx_fixed_pin: assert property (@(posedge core_clk_i) disable iff (rst_i)
		periph_route_reg_a_i[1] |=> pin_sig[5] == 4'h1) // see [RULE_03]
		else $error("rx not on pin 5");
	chk_off_no_drive: assert property (@(posedge core_clk_i) disable iff (rst_i)
		!xbar_on |-> pad_oe_o == 8'h00) // see [RULE_18]
		else $error("driver on while disabled");
	chk_analog_quiet: assert property (@(posedge core_clk_i) disable iff (rst_i)
		((pad_oe_o | pullup_en_o | port_read_o) & ~dig_mode) == 8'h00) // see [RULE_12]
		else $error("analog pin active");
	chk_skip_pin0: assert property (@(posedge core_clk_i) disable iff (rst_i)
		$past(pin_skip_reg_i[0]) && !periph_route_reg_a_i[0] |->
		pin_sig[0] == 4'hF) // see [RULE_05]
		else $error("skipped pin assigned");
	chk_first_free: assert property (@(posedge core_clk_i) disable iff (rst_i)
		$past(periph_route_reg_a_i) == 8'h04 && $past(pin_skip_reg_i) == 8'h00
		|-> pin_sig[0] == 4'h2 && pin_sig[1] == 4'h3) // see [RULE_02]
		else $error("bus pins not lowest");
	chk_bus_opendrain: assert property (@(posedge core_clk_i) disable iff (rst_i)
		pin_sig[0] == 4'h2 |-> !(pad_oe_o[0] && pad_o[0])) // see [RULE_14]
		else $error("bus pin drives high");
	chk_pullup_low: assert property (@(posedge core_clk_i) disable iff (rst_i)
		((pad_oe_o & ~pad_o) & pullup_en_o) == 8'h00) // see [RULE_16]
		else $error("pullup on low drive");
endmodule
`default_nettype wire

// file: src/xbar_map.svh
// Overview of operation
// [RULE_01] fixed priority order of peripheral signals
// [RULE_02] lowest free unskipped pin per signal
// [RULE_03] serial transmit pin 4, receive pin 5
// [RULE_04] assigned pins passed over by later signals
// [RULE_05] skip bit set treats pin as assigned
// [RULE_06] only pins 0 to 6 skippable
// [RULE_07] bus enable places data and clock both
// [RULE_08] leftover pins act as general-purpose pins
// [RULE_09] software skips pins claimed outside crossbar
// [RULE_10] software configures modes, skips, enables, then enable
// [RULE_11] input mode 1 digital, reset digital
// [RULE_12] analog pin: no pullup, driver, receiver
// [RULE_13] driver type from output-mode bit, except bus data and clock
// [RULE_14] bus data and clock always open-drain
// [RULE_15] pullup on open-drain pins unless disabled
// [RULE_16] pullup off while pin drives low
// [RULE_17] crossbar disabled: all pins plain inputs
// [RULE_18] output drivers off while crossbar disabled
// [RULE_19] enable activates routing from current settings
// [RULE_20] software skips every analog input pin
// [RULE_21] analog pin reads back as zero
// [RULE_22] capture select routes zero to three outputs
// [RULE_23] signals without free pin are dropped
// [RULE_24] routing recomputed clock edge after change
`ifndef XBAR_MAP_SVH
`define XBAR_MAP_SVH
`define XB_PINS        8
`define XB_SIGS        13
`define XB_IDXW        4
`define XB_TX_PIN      3'h4
`define XB_RX_PIN      3'h5
`define XB_SKIP_MASK   8'h7F
`define XB_NONE        4'hF
`define XB_S_TX        0
`define XB_S_RX        1
`define XB_S_SDA       2
`define XB_S_SCL       3
`define XB_S_CMP       4
`define XB_S_CMPA      5
`define XB_S_SYSCLK    6
`define XB_S_CAP0      7
`define XB_S_CAP1      8
`define XB_S_CAP2      9
`define XB_S_ECI       10
`define XB_S_T0        11
`define XB_S_T1        12
`endif

// file: src/xbar_pkg.sv
package xbar_pkg;
	typedef logic [3:0] sig_idx_t;
	typedef logic [7:0] pin_vec_t;
endpackage

// file: testbench/pad_world.sv
`timescale 1ns/1ps
`default_nettype none
// far side: port pads with an external driver and the weak pullup
module pad_world
(
	// from the mux
	input  wire logic [7:0] pad_o,
	input  wire logic [7:0] pad_oe_o,
	input  wire logic [7:0] pullup_en_o,
	// board side driver, changed by the bench each test
	input  wire logic [7:0] ext_lvl,
	// resolved pad level
	output logic      [7:0] pad
);
	// driven pins follow the mux, pulled pins read high, else the board
	always_comb
	begin
		for (int p = 0; p < 8; p++)
			pad[p] = pad_oe_o[p] ? pad_o[p] : (pullup_en_o[p] ? 1'b1 : ext_lvl[p]);
	end
endmodule
`default_nettype wire

// file: testbench/tb_priority_crossbar_port_mux.sv
`timescale 1ns/1ps
`default_nettype none
module tb_priority_crossbar_port_mux;
	logic core_clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic [7:0] sk = 8'h00, ra = 8'h00, rb = 8'h00, im = 8'hFF, om = 8'h00;
	logic [7:0] lt = 8'h00, ext = 8'h00;
	logic [12:0] per = 13'h0000;
	logic [7:0] pad, pad_o, oe, pu, rd, ro;
	logic [7:0] e_ro, e_oe, e_pu, e_vo;
	int err_count = 0, n_tests = 0, seed = 16;

	always #10 core_clk_i = ~core_clk_i;

	priority_crossbar_port_mux priority_crossbar_port_mux_i (
		.core_clk_i(core_clk_i), .rst_i(rst_i), .pin_skip_reg_i(sk),
		.periph_route_reg_a_i(ra), .periph_route_reg_b_i(rb),
		.port_input_mode_i(im), .port_output_mode_i(om), .port_latch_i(lt),
		.serial_transmit_out_i(per[0]), .bus_data_out_i(per[2]),
		.bus_clock_out_i(per[3]), .comparator_out_i(per[4]),
		.comparator_async_out_i(per[5]), .sysclk_out_i(per[6]),
		.capture_out_i(per[9:7]), .serial_receive_in_o(),
		.bus_data_in_o(), .bus_clock_in_o(), .capture_in_o(),
		.counter_external_input_o(), .timer_zero_input_o(),
		.timer_one_input_o(), .pad_i(pad), .pad_o(pad_o), .pad_oe_o(oe),
		.pullup_en_o(pu), .port_read_o(rd), .pin_routed_o(ro));

	pad_world pad_world_i (.pad_o(pad_o), .pad_oe_o(oe), .pullup_en_o(pu),
		.ext_lvl(ext), .pad(pad));

	// reference routing walk over the priority chain
	task automatic calc();
		logic [12:0] en;
		logic [7:0] tk, io, bus, od;
		int p;
		en = {rb[2:0], ra[7:6] == 2'h3, ra[7], ra[7:6] != 2'h0, ra[3], ra[5],
			ra[4], ra[2], ra[2], ra[1:0]};
		tk = sk & 8'h7F;
		e_ro = 8'h00; e_vo = lt; io = 8'h00; bus = 8'h00;
		for (int s = 0; s < 13; s++)
		begin
			p = 8;
			if (en[s] && s < 2)
				p = 4 + s;
			else if (en[s])
				for (int q = 7; q >= 0; q--)
					if (!tk[q] && !(q == 4 && en[0]) && !(q == 5 && en[1]))
						p = q;
			if (p < 8)
			begin
				tk[p] = 1'b1;
				e_ro[p] = 1'b1;
				if (s == 1 || s > 9)
					io[p] = 1'b1;
				else
					e_vo[p] = per[s];
				if (s == 2 || s == 3)
					bus[p] = 1'b1;
			end
		end
		if (!rb[6])
			e_ro = 8'h00;
		od = ~om | bus;
		e_oe = rb[6] ? im & ~io & (~od | ~e_vo) : 8'h00;
		e_pu = im & ~{8{rb[7]}} & (~{8{rb[6]}} | (od & ~(e_oe & ~e_vo)));
	endtask

	task automatic chk(input string what, input logic [7:0] got, exp);
		n_tests++;
		if (got !== exp)
		begin
			err_count++;
			$display("CHECK FAILED t=%0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask

	// apply settings in one edge, let routing and pad sync settle
	task automatic run(input logic [7:0] s, a, b, m_in, m_out);
		@(posedge core_clk_i);
		im <= m_in; om <= m_out; sk <= s; ra <= a; rb <= b;
		lt <= $random(seed); per <= $random(seed); ext <= $random(seed);
		repeat (6) @(posedge core_clk_i);
		#1 calc();
		chk("routed", ro, e_ro);
		chk("enable", oe, e_oe);
		chk("pullup", pu, e_pu);
		chk("drive", pad_o & oe, e_vo & e_oe);
		chk("read", rd, pad & im);
		$display("test done skip %h a %h b %h", s, a, b);
	endtask

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	initial
	begin
		#200000;
		err_count++;
		wrap_up();
	end

	initial
	begin
		repeat (12) @(posedge core_clk_i);
		#1 calc();
		chk("reset pullup", pu, e_pu);
		chk("reset drive", oe, 8'h00);
		rst_i <= 1'b0;
		run(8'h00, 8'h04, 8'h40, 8'hFF, 8'hFF);
		run(8'hFF, 8'hFF, 8'h47, 8'hFF, 8'hFF);
		run(8'h00, 8'hFF, 8'h87, 8'hFF, 8'h00);
		run(8'h09, 8'hFF, 8'h07, 8'hF6, 8'hFF);
		run(8'h41, 8'h3F, 8'h40, 8'hBE, 8'h0F);
		for (int i = 0; i < 300; i++)
			run($random(seed), $random(seed), $random(seed), $random(seed),
				$random(seed));
		wrap_up();
	end
endmodule
`default_nettype wire
